// file: spsc_pkg.sv
// shared types and constants of the system power-state controller
package spsc_pkg;
    // clock and timebase
    localparam int unsigned CLK_HZ            = 40_000_000;
    localparam int unsigned TICK_US           = 1000;          // slow timebase period, us
    localparam int unsigned TICK_CYC          = (CLK_HZ / 1_000_000) * TICK_US;
    localparam int unsigned LONG_PRESS_MS     = 4000;          // four-second threshold
    localparam int unsigned LONG_PRESS_TICKS  = LONG_PRESS_MS * 1000 / TICK_US;
    localparam int unsigned DEBOUNCE_MS       = 20;
    localparam int unsigned DEBOUNCE_TICKS    = DEBOUNCE_MS * 1000 / TICK_US;
    localparam int unsigned STBY_TIMEOUT_MS   = 600_000;       // ten minutes default
    localparam int unsigned STBY_TIMEOUT_TICKS = STBY_TIMEOUT_MS * 1000 / TICK_US;
    localparam int unsigned TICK_W            = 16;
    localparam int unsigned PRESS_W           = 16;
    localparam int unsigned IDLE_W            = 24;

    // one-hot system states
    typedef enum logic [5:0] {
        SPSC_ST_MECH_OFF = 6'h01,
        SPSC_ST_SOFT_OFF = 6'h02,
        SPSC_ST_WORKING  = 6'h04,
        SPSC_ST_SLEEP_S1 = 6'h08,
        SPSC_ST_SLEEP_S3 = 6'h10,
        SPSC_ST_STANDBY  = 6'h20
    } spsc_state_type;

    // wake sources, one bit each
    typedef struct packed {
        logic rtc_alarm;
        logic pme;
        logic modem;
        logic ir_cmd;
        logic usb;
        logic keyboard;
        logic lan_conn;
    } spsc_wake_type;

    // power rails and device controls that follow the state
    typedef struct packed {
        logic main_power;
        logic cpu_power;
        logic cpu_stop;
        logic mem_self_refresh;
        logic dev_d3;
        logic wake_logic_on;
        logic disk_spin_down;
        logic monitor_off;
    } spsc_power_type;

    localparam int unsigned WAKE_W = 7;
endpackage

// file: spsc_sync.sv
// three-stage synchroniser with agreement on the last two stages
`timescale 1ns/1ps
module spsc_sync #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             reset,
    // raw and settled levels
    input  wire logic [WIDTH-1:0] raw,
    output logic      [WIDTH-1:0] level
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] level_r;
    wire  [WIDTH-1:0] agree = ~(s2_r ^ s3_r);

    // only the second stage reads the first, to keep metastability contained
    always_ff @(posedge mclk) begin
        if (reset) begin
            s1_r    <= '0;
            s2_r    <= '0;
            s3_r    <= '0;
            level_r <= '0;
        end else begin
            s1_r    <= raw;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            level_r <= (agree & s3_r) | (~agree & level_r);
        end
    end

    assign level = level_r;
endmodule

// file: spsc_press_timer.sv
// power switch debounce and press-length measurement on the slow timebase
`timescale 1ns/1ps
module spsc_press_timer #(
    parameter int unsigned LONG_TICKS = spsc_pkg::LONG_PRESS_TICKS,
    parameter int unsigned DEB_TICKS  = spsc_pkg::DEBOUNCE_TICKS
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic reset,
    // timebase and synchronised switch
    input  wire logic tick,
    input  wire logic sw_level,
    // press results, one-cycle pulses
    output logic      short_press,
    output logic      long_press
);
    logic [spsc_pkg::PRESS_W-1:0] deb_cnt_r;
    logic [spsc_pkg::PRESS_W-1:0] held_cnt_r;
    logic                         pressed_r;
    logic                         long_done_r;
    logic                         short_r;
    logic                         long_r;

    wire deb_done   = deb_cnt_r >= spsc_pkg::PRESS_W'(DEB_TICKS);
    wire deb_change = sw_level != pressed_r;
    wire deb_take   = deb_change && deb_done;
    wire long_hit   = pressed_r && !long_done_r && tick &&
                      (held_cnt_r == spsc_pkg::PRESS_W'(LONG_TICKS - 1));

    // debounce: a new level must stand for the debounce time; length counted in ticks
    always_ff @(posedge mclk) begin
        if (reset) begin
            deb_cnt_r   <= '0;
            held_cnt_r  <= '0;
            pressed_r   <= 1'b0;
            long_done_r <= 1'b0;
            short_r     <= 1'b0;
            long_r      <= 1'b0;
        end else begin
            short_r <= deb_take && pressed_r && !long_done_r;
            long_r  <= long_hit;
            if (!deb_change) begin
                deb_cnt_r <= '0;
            end else if (tick && !deb_done) begin
                deb_cnt_r <= deb_cnt_r + 1'b1;
            end
            if (deb_take) begin
                pressed_r   <= sw_level;
                held_cnt_r  <= '0;
                long_done_r <= 1'b0;
                deb_cnt_r   <= '0;
            end else begin
                if (pressed_r && tick && !long_done_r) begin
                    held_cnt_r <= held_cnt_r + 1'b1;
                end
                if (long_hit) begin
                    long_done_r <= 1'b1;  // release after a long press is ignored
                end
            end
        end
    end

    assign short_press = short_r;
    assign long_press  = long_r;
endmodule

// file: spsc_top.sv
// system power-state controller: switch timing, wake qualification, legacy standby
`timescale 1ns/1ps

module spsc_top #(
    parameter int unsigned TICK_CYC     = spsc_pkg::TICK_CYC,
    parameter int unsigned LONG_TICKS   = spsc_pkg::LONG_PRESS_TICKS,
    parameter int unsigned DEB_TICKS    = spsc_pkg::DEBOUNCE_TICKS,
    parameter int unsigned IDLE_TICKS   = spsc_pkg::STBY_TIMEOUT_TICKS
) (
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   reset,
    // supply presence
    input  wire logic                   ac_present,
    input  wire logic                   aux_power_ok,
    // front-panel switch, high while pressed
    input  wire logic                   power_switch,
    // wake sources, raw pins
    input  wire spsc_pkg::spsc_wake_type wake_raw,
    input  wire logic                   mouse_activity,
    input  wire logic                   service_request,
    // software controls, same clock
    input  wire logic                   os_power_control,
    input  wire logic                   pm_enable,
    input  wire logic                   sw_standby_req,
    input  wire logic                   sw_sleep_s3,
    input  wire logic                   sw_soft_off_req,
    // state and power outputs
    output spsc_pkg::spsc_state_type    sys_state,
    output spsc_pkg::spsc_power_type    power_ctl,
    output logic                        service_enable,
    output logic                        wake_event
);
    localparam int unsigned SYNC_W = spsc_pkg::WAKE_W + 4;

    // --------------------------------------------------------------
    // input synchronisation
    // --------------------------------------------------------------
    logic [SYNC_W-1:0]       sync_level;
    spsc_pkg::spsc_wake_type wake_s;
    logic                    sw_s;
    logic                    mouse_s;
    logic                    svc_s;
    logic                    ac_s;

    spsc_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .mclk  (mclk),
        .reset (reset),
        .raw   ({wake_raw, power_switch, mouse_activity, service_request, ac_present}),
        .level (sync_level)
    );

    assign wake_s  = sync_level[SYNC_W-1:4];
    assign sw_s    = sync_level[3];
    assign mouse_s = sync_level[2];
    assign svc_s   = sync_level[1];
    assign ac_s    = sync_level[0];

    // --------------------------------------------------------------
    // slow timebase
    // --------------------------------------------------------------
    logic [spsc_pkg::TICK_W-1:0] tick_cnt_r;
    logic                        tick_r;
    wire                         tick_wrap = tick_cnt_r == spsc_pkg::TICK_W'(TICK_CYC - 1);

    // one tick per timebase period feeds the press and idle counters
    always_ff @(posedge mclk) begin
        if (reset) begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b0;
        end else begin
            tick_cnt_r <= tick_wrap ? '0 : tick_cnt_r + 1'b1;
            tick_r     <= tick_wrap;
        end
    end

    // --------------------------------------------------------------
    // power switch timing
    // --------------------------------------------------------------
    logic short_press;
    logic long_press;

    spsc_press_timer #(
        .LONG_TICKS (LONG_TICKS),
        .DEB_TICKS  (DEB_TICKS)
    ) u_press (
        .mclk        (mclk),
        .reset       (reset),
        .tick        (tick_r),
        .sw_level    (sw_s),
        .short_press (short_press),
        .long_press  (long_press)
    );

    // --------------------------------------------------------------
    // wake edge detection and qualification
    // --------------------------------------------------------------
    spsc_pkg::spsc_wake_type wake_d_r;
    logic                    mouse_d_r;
    spsc_pkg::spsc_state_type state_r;
    spsc_pkg::spsc_state_type state_nxt;

    wire spsc_pkg::spsc_wake_type wake_rise = wake_s & ~wake_d_r;
    wire mouse_rise = mouse_s & ~mouse_d_r;

    wire in_s1   = state_r == spsc_pkg::SPSC_ST_SLEEP_S1;
    wire in_s3   = state_r == spsc_pkg::SPSC_ST_SLEEP_S3;
    wire in_s5   = state_r == spsc_pkg::SPSC_ST_SOFT_OFF;
    wire in_work = state_r == spsc_pkg::SPSC_ST_WORKING;
    wire in_stby = state_r == spsc_pkg::SPSC_ST_STANDBY;
    wire in_g3   = state_r == spsc_pkg::SPSC_ST_MECH_OFF;
    wire in_slp  = in_s1 || in_s3;

    // sources allowed from S1, S3 and soft-off
    wire wake_any_state = wake_rise.rtc_alarm || wake_rise.pme;
    // sources that need the sleep-state wake logic powered
    wire wake_sleep_only = wake_rise.modem || wake_rise.ir_cmd ||
                           wake_rise.usb || wake_rise.keyboard;
    wire wake_from_sleep = in_slp && (wake_any_state || wake_sleep_only);
    wire wake_from_off   = in_s5 && (wake_any_state || wake_rise.lan_conn);

    // --------------------------------------------------------------
    // legacy standby inactivity timer
    // --------------------------------------------------------------
    logic [spsc_pkg::IDLE_W-1:0] idle_cnt_r;
    wire legacy_mode  = !os_power_control;
    wire activity     = wake_rise.keyboard || mouse_rise;
    wire idle_expire  = pm_enable && legacy_mode && in_work && tick_r &&
                        (idle_cnt_r == spsc_pkg::IDLE_W'(IDLE_TICKS - 1));
    wire stby_request = legacy_mode && in_work && sw_standby_req;
    wire stby_exit    = in_stby && activity;

    // idle count restarts on any activity and outside working
    always_ff @(posedge mclk) begin
        if (reset) begin
            idle_cnt_r <= '0;
        end else if (!in_work || activity || !pm_enable) begin
            idle_cnt_r <= '0;
        end else if (tick_r && !idle_expire) begin
            idle_cnt_r <= idle_cnt_r + 1'b1;
        end
    end

    // --------------------------------------------------------------
    // system state machine
    // --------------------------------------------------------------
    wire g3_enter  = !ac_s && !aux_power_ok;
    logic wake_nxt;

    always_comb begin
        state_nxt = state_r;
        wake_nxt  = 1'b0;
        if (g3_enter) begin
            state_nxt = spsc_pkg::SPSC_ST_MECH_OFF;
        end else begin
            unique case (state_r)
                spsc_pkg::SPSC_ST_MECH_OFF: begin
                    // power back: come up soft-off and wait for a wake source
                    state_nxt = spsc_pkg::SPSC_ST_SOFT_OFF;
                end
                spsc_pkg::SPSC_ST_SOFT_OFF: begin
                    if (short_press || wake_from_off) begin
                        state_nxt = spsc_pkg::SPSC_ST_WORKING;
                        wake_nxt  = 1'b1;
                    end
                end
                spsc_pkg::SPSC_ST_WORKING: begin
                    if (long_press || sw_soft_off_req) begin
                        state_nxt = spsc_pkg::SPSC_ST_SOFT_OFF;
                    end else if (short_press) begin
                        state_nxt = sw_sleep_s3 ? spsc_pkg::SPSC_ST_SLEEP_S3
                                                : spsc_pkg::SPSC_ST_SLEEP_S1;
                    end else if (idle_expire || stby_request) begin
                        state_nxt = spsc_pkg::SPSC_ST_STANDBY;
                    end
                end
                spsc_pkg::SPSC_ST_SLEEP_S1,
                spsc_pkg::SPSC_ST_SLEEP_S3: begin
                    if (long_press) begin
                        state_nxt = spsc_pkg::SPSC_ST_SOFT_OFF;
                    end else if (short_press || wake_from_sleep) begin
                        state_nxt = spsc_pkg::SPSC_ST_WORKING;
                        wake_nxt  = 1'b1;
                    end
                end
                spsc_pkg::SPSC_ST_STANDBY: begin
                    if (long_press) begin
                        state_nxt = spsc_pkg::SPSC_ST_SOFT_OFF;
                    end else if (stby_exit || short_press) begin
                        state_nxt = spsc_pkg::SPSC_ST_WORKING;
                        wake_nxt  = 1'b1;
                    end
                end
                default: begin
                    state_nxt = spsc_pkg::SPSC_ST_MECH_OFF;  // illegal code recovers safe
                end
            endcase
        end
    end

    // state and edge history registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_r   <= spsc_pkg::SPSC_ST_MECH_OFF;
            wake_d_r  <= '0;
            mouse_d_r <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            wake_d_r  <= wake_s;
            mouse_d_r <= mouse_s;
        end
    end

    // --------------------------------------------------------------
    // power controls derived from the next state
    // --------------------------------------------------------------
    wire nx_work = state_nxt == spsc_pkg::SPSC_ST_WORKING;
    wire nx_s1   = state_nxt == spsc_pkg::SPSC_ST_SLEEP_S1;
    wire nx_s3   = state_nxt == spsc_pkg::SPSC_ST_SLEEP_S3;
    wire nx_s5   = state_nxt == spsc_pkg::SPSC_ST_SOFT_OFF;
    wire nx_stby = state_nxt == spsc_pkg::SPSC_ST_STANDBY;
    wire nx_g3   = state_nxt == spsc_pkg::SPSC_ST_MECH_OFF;

    spsc_pkg::spsc_power_type pwr_nxt;
    assign pwr_nxt.main_power       = nx_work || nx_s1 || nx_stby;
    assign pwr_nxt.cpu_power        = nx_work || nx_s1 || nx_stby;
    assign pwr_nxt.cpu_stop         = nx_s1;
    assign pwr_nxt.mem_self_refresh = nx_s3;
    assign pwr_nxt.dev_d3           = nx_s3 || nx_s5 || nx_g3;
    // wake logic stays up in S1, S3 and soft-off; off in G3, which is entered only with aux_power_ok low
    assign pwr_nxt.wake_logic_on    = nx_s1 || nx_s3 || nx_s5 ||
                                      (nx_g3 && aux_power_ok);
    assign pwr_nxt.disk_spin_down   = nx_stby || nx_s3 || nx_s5 || nx_g3;
    assign pwr_nxt.monitor_off      = !(nx_work || nx_s1) || nx_s1;

    // service path stays open in standby so interrupts are still handled
    wire svc_nxt = (nx_work || nx_stby) && (svc_s || 1'b1);

    spsc_pkg::spsc_power_type pwr_r;
    logic                     svc_r;
    logic                     wake_r;

    // outputs registered; monitor restored in the same edge as standby exit
    always_ff @(posedge mclk) begin
        if (reset) begin
            pwr_r  <= '0;
            svc_r  <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            pwr_r  <= pwr_nxt;
            svc_r  <= svc_nxt;
            wake_r <= wake_nxt;
        end
    end

    assign sys_state      = state_r;
    assign power_ctl      = pwr_r;
    assign service_enable = svc_r;
    assign wake_event     = wake_r;
endmodule

// file: spsc_top_monitor.sv
// assertion checker for the system power-state controller
`timescale 1ns/1ps
module spsc_monitor #(
    parameter int unsigned TICK_CYC   = spsc_pkg::TICK_CYC,
    parameter int unsigned LONG_TICKS = spsc_pkg::LONG_PRESS_TICKS,
    parameter int unsigned DEB_TICKS  = spsc_pkg::DEBOUNCE_TICKS
) (
    // clock and reset
    input wire logic                     mclk,
    input wire logic                     reset,
    // watched inputs
    input wire logic                     power_switch,
    input wire logic                     mouse_activity,
    input wire logic                     os_power_control,
    input wire logic                     pm_enable,
    input wire logic                     sw_standby_req,
    // watched outputs
    input wire spsc_pkg::spsc_state_type sys_state,
    input wire spsc_pkg::spsc_power_type power_ctl,
    input wire logic                     service_enable,
    input wire logic                     wake_event
);
    // ----
    // held-switch counter
    // ----
    // bound covers sync, worst tick phase of debounce and count, and state update
    localparam int unsigned              LIM = (DEB_TICKS + LONG_TICKS + 2) * TICK_CYC + 8;
    localparam spsc_pkg::spsc_state_type G3  = spsc_pkg::SPSC_ST_MECH_OFF;
    localparam spsc_pkg::spsc_state_type OFF = spsc_pkg::SPSC_ST_SOFT_OFF;
    localparam spsc_pkg::spsc_state_type WRK = spsc_pkg::SPSC_ST_WORKING;
    localparam spsc_pkg::spsc_state_type S3  = spsc_pkg::SPSC_ST_SLEEP_S3;
    localparam spsc_pkg::spsc_state_type SBY = spsc_pkg::SPSC_ST_STANDBY;
    logic [31:0] held_r;
    logic [31:0] held_nxt;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // saturates so a very long hold keeps the check armed
    assign held_nxt = !power_switch ? 32'h0 : (held_r == LIM) ? held_r : held_r + 32'h1;
    always_ff @(posedge mclk) begin
        if (reset) held_r <= 32'h0;
        else held_r <= held_nxt;
    end
    // ----
    // assertions
    // ----
    property p_wake_pulse;
        wake_event |-> sys_state == WRK && $past(sys_state) != WRK;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse)
        else $error("wake pulse without entry to working");
    property p_enter_pulse;
        sys_state == WRK && $past(sys_state) != WRK |-> wake_event;
    endproperty
    a_enter_pulse: assert property (p_enter_pulse)
        else $error("entry to working without wake pulse");
    property p_s3_mem;
        sys_state == S3 |-> power_ctl.mem_self_refresh && !power_ctl.cpu_power;
    endproperty
    a_s3_mem: assert property (p_s3_mem)
        else $error("suspend state without memory hold or with cpu power");
    property p_s3_dev;
        sys_state == S3 |-> power_ctl.dev_d3 && power_ctl.wake_logic_on;
    endproperty
    a_s3_dev: assert property (p_s3_dev)
        else $error("suspend state without devices low or wake logic on");
    property p_g3_dark;
        sys_state == G3 |-> !power_ctl.main_power && !power_ctl.cpu_power;
    endproperty
    a_g3_dark: assert property (p_g3_dark)
        else $error("mechanical off with power on");
    property p_sby_power;
        sys_state == SBY |-> power_ctl.disk_spin_down && power_ctl.monitor_off;
    endproperty
    a_sby_power: assert property (p_sby_power)
        else $error("standby without disk spin-down or monitor off");
    property p_sby_svc;
        sys_state == SBY |-> service_enable;
    endproperty
    a_sby_svc: assert property (p_sby_svc)
        else $error("standby stopped servicing requests");
    property p_sby_entry;
        sys_state == SBY && $past(sys_state) == WRK
            |-> $past(pm_enable) || $past(sw_standby_req) || $past(sw_standby_req, 2);
    endproperty
    a_sby_entry: assert property (p_sby_entry)
        else $error("standby entered without enable or request");
    property p_sby_os;
        sys_state == SBY && $past(sys_state) == WRK |-> !$past(os_power_control);
    endproperty
    a_sby_os: assert property (p_sby_os)
        else $error("standby entered while the os owns power control");
    property p_mouse_exit;
        $rose(mouse_activity) && sys_state == SBY |-> ##[1:10] sys_state == WRK;
    endproperty
    a_mouse_exit: assert property (p_mouse_exit)
        else $error("mouse activity did not end standby");
    property p_long_held;
        held_r == LIM |-> sys_state == OFF || sys_state == G3;
    endproperty
    a_long_held: assert property (p_long_held)
        else $error("long hold did not force soft-off while held");
endmodule

bind spsc_top spsc_monitor #(
    .TICK_CYC   (TICK_CYC),
    .LONG_TICKS (LONG_TICKS),
    .DEB_TICKS  (DEB_TICKS)
) u_monitor (
    .mclk             (mclk),
    .reset            (reset),
    .power_switch     (power_switch),
    .mouse_activity   (mouse_activity),
    .os_power_control (os_power_control),
    .pm_enable        (pm_enable),
    .sw_standby_req   (sw_standby_req),
    .sys_state        (sys_state),
    .power_ctl        (power_ctl),
    .service_enable   (service_enable),
    .wake_event       (wake_event)
);

// file: spsc_far_side.sv
// far-side model: front-panel switch, wake sources and mouse
`timescale 1ns/1ps
module spsc_far_side (
    // clock
    input  wire logic               mclk,
    // switch and event pins
    output logic                    power_switch,
    output spsc_pkg::spsc_wake_type wake_raw,
    output logic                    mouse_activity
);
    logic [6:0] wake_bits = 7'h00;
    // pins rest low between events
    assign wake_raw = wake_bits;
    initial {power_switch, mouse_activity} = 2'h0;
    // switch level moves only just after a falling edge
    task automatic set_switch(input logic v);
        @(negedge mclk);
        power_switch = v;
    endtask
    // index 7 is the mouse; held 8 cycles so the synchroniser cannot miss it
    task automatic pulse(input int idx);
        @(negedge mclk);
        if (idx == 7) mouse_activity = 1'b1;
        else wake_bits[idx] = 1'b1;
        repeat (8) @(negedge mclk);
        mouse_activity = 1'b0;
        wake_bits      = 7'h00;
        repeat (20) @(negedge mclk);
    endtask
endmodule

// file: spsc_bench.sv
// self-checking bench for the system power-state controller
`timescale 1ns/1ps
module spsc_bench;
    // ----
    // sim-sized counts and stimulus
    // ----
    localparam int unsigned              TCK = 4;
    localparam int unsigned              IDL = 20;
    localparam spsc_pkg::spsc_state_type G3  = spsc_pkg::SPSC_ST_MECH_OFF;
    localparam spsc_pkg::spsc_state_type OFF = spsc_pkg::SPSC_ST_SOFT_OFF;
    localparam spsc_pkg::spsc_state_type WRK = spsc_pkg::SPSC_ST_WORKING;
    localparam spsc_pkg::spsc_state_type S1  = spsc_pkg::SPSC_ST_SLEEP_S1;
    localparam spsc_pkg::spsc_state_type S3  = spsc_pkg::SPSC_ST_SLEEP_S3;
    localparam spsc_pkg::spsc_state_type SBY = spsc_pkg::SPSC_ST_STANDBY;
    logic mclk             = 1'b0;
    logic reset            = 1'b1;
    logic ac_present;
    logic aux_power_ok;
    logic service_request;
    logic os_power_control;
    logic pm_enable;
    logic sw_standby_req;
    logic sw_sleep_s3;
    logic sw_soft_off_req;
    logic power_switch;
    logic mouse_activity;
    logic service_enable;
    logic wake_event;
    bit   ok;
    int   seed             = 13524;
    int   mismatches       = 0;
    int   tests_run        = 0;
    spsc_pkg::spsc_wake_type  wake_raw;
    spsc_pkg::spsc_state_type sys_state;
    spsc_pkg::spsc_state_type st;
    spsc_pkg::spsc_state_type last_st = spsc_pkg::SPSC_ST_MECH_OFF;
    spsc_pkg::spsc_state_type exp_q[$];
    spsc_pkg::spsc_power_type power_ctl;

    always #12.5 mclk = ~mclk;
    spsc_top #(.TICK_CYC(TCK), .LONG_TICKS(8), .DEB_TICKS(2), .IDLE_TICKS(IDL)) dut (
        .mclk(mclk), .reset(reset), .ac_present(ac_present), .aux_power_ok(aux_power_ok),
        .power_switch(power_switch), .wake_raw(wake_raw), .mouse_activity(mouse_activity),
        .service_request(service_request), .os_power_control(os_power_control),
        .pm_enable(pm_enable), .sw_standby_req(sw_standby_req), .sw_sleep_s3(sw_sleep_s3),
        .sw_soft_off_req(sw_soft_off_req), .sys_state(sys_state), .power_ctl(power_ctl),
        .service_enable(service_enable), .wake_event(wake_event));
    spsc_far_side far (.mclk(mclk), .power_switch(power_switch), .wake_raw(wake_raw),
        .mouse_activity(mouse_activity));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // short hold stays well past debounce yet just below the long threshold
    function automatic int sh();
        return 24 + ($unsigned($random(seed)) % 4);
    endfunction
    task automatic press(input int hold);
        far.set_switch(1'b1);
        repeat (hold) @(negedge mclk);
        far.set_switch(1'b0);
        repeat (50) @(negedge mclk);
    endtask
    task automatic long_press();
        exp_q.push_back(OFF);
        far.set_switch(1'b1);
        repeat (70) @(negedge mclk);
        check("held", 8'(sys_state), 8'(OFF));
        far.set_switch(1'b0);
        repeat (50) @(negedge mclk);
    endtask
    task automatic strobe(input bit stby);
        @(negedge mclk);
        if (stby) sw_standby_req = 1'b1;
        else sw_soft_off_req = 1'b1;
        @(negedge mclk);
        sw_standby_req  = 1'b0;
        sw_soft_off_req = 1'b0;
        repeat (10) @(negedge mclk);
    endtask

    // every state change takes the oldest expectation off the queue
    always @(negedge mclk) begin
        service_request <= 1'($random(seed));
        if (!reset && sys_state !== last_st) begin
            last_st = sys_state;
            if (exp_q.size() == 0) check("spare change", 8'(sys_state), 8'hFF);
            else check("state", 8'(sys_state), 8'(exp_q.pop_front()));
        end
    end
    // watchdog sized well above the roughly 3300 cycles of the sequence
    initial begin
        repeat (30000) @(posedge mclk);
        mismatches++;
        complete_run();
    end
    initial begin
        {ac_present, aux_power_ok, os_power_control, pm_enable} = 4'hC;
        {sw_standby_req, sw_sleep_s3, sw_soft_off_req} = 3'h0;
        repeat (16) @(negedge mclk);
        exp_q.push_back(OFF);
        reset = 1'b0;
        repeat (20) @(negedge mclk);
        exp_q.push_back(WRK);
        press(sh());
        // every wake source from S1, S3 and soft-off
        for (int s = 0; s < 3; s++) begin
            for (int b = 0; b < 7; b++) begin
                ok = (s == 2) ? (b == 0 || b >= 5) : (b != 0);
                st = (s == 0) ? S1 : (s == 1) ? S3 : OFF;
                sw_sleep_s3 = (s == 1);
                exp_q.push_back(st);
                if (s == 2) strobe(1'b0);
                else press(sh());
                exp_q.push_back(WRK);
                far.pulse(b);
                check("wake", 8'(sys_state), ok ? 8'(WRK) : 8'(st));
                if (!ok) press(sh());
            end
        end
        long_press();
        exp_q.push_back(WRK);
        press(sh());
        sw_sleep_s3 = 1'b0;
        exp_q.push_back(S1);
        press(sh());
        long_press();
        exp_q.push_back(WRK);
        press(sh());
        // legacy standby by timeout and by request
        exp_q.push_back(SBY);
        pm_enable = 1'b1;
        repeat (IDL * TCK + 20) @(negedge mclk);
        check("service", {7'h00, service_enable}, 8'h01);
        check("monitor", {7'h00, power_ctl.monitor_off}, 8'h01);
        exp_q.push_back(WRK);
        far.pulse(7);
        pm_enable = 1'b0;
        check("monitor on", {7'h00, power_ctl.monitor_off}, 8'h00);
        repeat (IDL * TCK + 40) @(negedge mclk);
        check("disabled", 8'(sys_state), 8'(WRK));
        exp_q.push_back(SBY);
        strobe(1'b1);
        exp_q.push_back(WRK);
        far.pulse(1);
        os_power_control = 1'b1;
        pm_enable = 1'b1;
        strobe(1'b1);
        repeat (IDL * TCK + 40) @(negedge mclk);
        check("os owns", 8'(sys_state), 8'(WRK));
        os_power_control = 1'b0;
        pm_enable = 1'b0;
        // loss of both supplies, then return
        exp_q.push_back(G3);
        ac_present = 1'b0;
        aux_power_ok = 1'b0;
        repeat (20) @(negedge mclk);
        check("dark", {5'h00, power_ctl[7:6], power_ctl.wake_logic_on}, 8'h00);
        exp_q.push_back(OFF);
        ac_present = 1'b1;
        aux_power_ok = 1'b1;
        repeat (20) @(negedge mclk);
        check("queue", 8'(exp_q.size()), 8'h00);
        complete_run();
    end
endmodule
